/* hw/msg_gate.sv */
/*
 Holds the receive FIFO and the monitor security gate top module.
 Assumes framed host bytes arrive with valid/ready, the CPU executes the
 requested stacking operations, and the power-on flag is valid at entry.
*/
`timescale 1ns/1ps
`default_nettype none

module msg_fifo
#(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
)
(
	// Clock and reset.
	input wire logic clock_i,
	input wire logic srst_i,
	// Fill side.
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	// Drain side.
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int unsigned AW = $clog2(DEPTH);

	typedef struct packed
	{
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] count;
		logic not_full;
	} msg_fifo_state_t;

	msg_fifo_state_t cur;
	msg_fifo_state_t next_cur;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop;

	assign push = in_valid_i && cur.not_full;
	assign pop = out_ready_i && (cur.count != '0);
	assign in_ready_o = cur.not_full;
	assign out_valid_o = (cur.count != '0);
	assign out_data_o = mem[cur.rd];

	always_comb
	begin
		next_cur = cur;
		if (push)
			next_cur.wr = (cur.wr == AW'(DEPTH - 1)) ? '0 : cur.wr + 1'b1;
		if (pop)
			next_cur.rd = (cur.rd == AW'(DEPTH - 1)) ? '0 : cur.rd + 1'b1;
		next_cur.count = cur.count + (AW+1)'(push) - (AW+1)'(pop);
		next_cur.not_full = (next_cur.count != (AW+1)'(DEPTH));
	end

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			cur <= '0;
			cur.not_full <= 1'b1;
		end
		else
			cur <= next_cur;
		if (push)
			mem[cur.wr] <= in_data_i;
	end
endmodule

module msg_gate
(
	// Clock and reset.
	input wire logic clock_i,
	input wire logic srst_i,
	// Mode entry and reset cause.
	input wire logic monitor_entry_i,
	input wire logic power_on_i,
	input wire logic mass_erase_done_i,
	// Host bytes from the monitor_serial_pin receiver.
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	output logic rx_ready_o,
	// Bytes and break to the monitor_serial_pin transmitter.
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	output logic tx_break_o,
	input wire logic tx_ready_i,
	// CPU operation requests.
	output logic cpu_op_valid_o,
	output msg_pkg::msg_op_t cpu_op_o,
	input wire logic cpu_op_done_i,
	input wire logic [15:0] stack_pointer_i,
	// Protected vector bytes, lowest address in the low byte.
	input wire logic [63:0] sec_code_i,
	// Flash guard.
	input wire logic flash_rd_i,
	input wire logic [7:0] flash_rd_data_i,
	input wire logic flash_fetch_i,
	output logic flash_valid_o,
	output logic [7:0] flash_data_o,
	output logic illegal_reset_o,
	output logic secure_bypass_o,
	// Status bit write to RAM.
	output logic ram_wr_o,
	output logic [7:0] ram_addr_o,
	output logic [7:0] ram_wdata_o
);
	import msg_pkg::*;

	typedef struct packed
	{
		msg_state_t st;
		logic [2:0] idx;
		logic match;
		logic bypass;
		logic erased;
		logic monitor;
		logic op_valid;
		msg_op_t op;
		logic tx_valid;
		logic [7:0] tx_data;
		logic tx_break;
		logic [7:0] sp_lo;
		logic fl_valid;
		logic [7:0] fl_data;
		logic illegal;
		logic ram_wr;
	} msg_state_s_t;

	msg_state_s_t cur;
	msg_state_s_t next_cur;
	logic fifo_valid;
	logic [7:0] fifo_data;
	logic fifo_ready;
	logic [15:0] sp_plus;

	// ******************************************
	// Stored security byte selection.
	// ******************************************
	function automatic logic [7:0] msg_code_byte(input logic [63:0] code, input logic [2:0] i, input logic erased);
		msg_code_byte = erased ? MSG_BLANK_BYTE : code[{i, 3'h0} +: 8];
	endfunction

	msg_fifo #(.WIDTH(MSG_FIFO_WIDTH), .DEPTH(MSG_FIFO_DEPTH)) u_fifo
	(
		.clock_i(clock_i),
		.srst_i(srst_i),
		.in_valid_i(rx_valid_i),
		.in_data_i(rx_data_i),
		.in_ready_o(rx_ready_o),
		.out_valid_o(fifo_valid),
		.out_data_o(fifo_data),
		.out_ready_i(fifo_ready)
	);

	assign fifo_ready = (cur.st == MSG_SEC_WAIT) || (cur.st == MSG_CMD);
	assign sp_plus = stack_pointer_i + MSG_SP_OFFSET;

	// ******************************************
	// Sequencer and flash guard.
	// ******************************************
	always_comb
	begin
		next_cur = cur;
		next_cur.fl_valid = flash_rd_i;
		next_cur.illegal = 1'b0;
		next_cur.ram_wr = 1'b0;
		if (mass_erase_done_i)
			next_cur.erased = 1'b1;
		if (flash_rd_i)
			next_cur.fl_data = (cur.monitor && !cur.bypass) ? MSG_INVALID_DATA : flash_rd_data_i;
		if (flash_fetch_i && cur.monitor && !cur.bypass)
			next_cur.illegal = 1'b1;
		if (cur.op_valid && cpu_op_done_i)
			next_cur.op_valid = 1'b0;
		if (cur.tx_valid && tx_ready_i)
		begin
			next_cur.tx_valid = 1'b0;
			next_cur.tx_break = 1'b0;
		end
		unique case (cur.st)
			MSG_IDLE:
			begin
				if (monitor_entry_i)
				begin
					next_cur.monitor = 1'b1;
					if (power_on_i)
						next_cur.bypass = 1'b0;
					next_cur.op_valid = 1'b1;
					next_cur.op = MSG_OP_SOFT_INTERRUPT;
					next_cur.st = MSG_STACK_SOFT_INT;
				end
			end
			MSG_STACK_SOFT_INT:
			begin
				if (cpu_op_done_i)
				begin
					next_cur.op_valid = 1'b1;
					next_cur.op = MSG_OP_PUSH_INDEX_HIGH;
					next_cur.st = MSG_STACK_PSH;
				end
			end
			MSG_STACK_PSH:
			begin
				if (cpu_op_done_i)
				begin
					next_cur.idx = '0;
					next_cur.match = 1'b1;
					next_cur.st = power_on_i ? MSG_SEC_WAIT : MSG_SEND_BREAK;
				end
			end
			MSG_SEC_WAIT:
			begin
				if (fifo_valid)
				begin
					next_cur.match = cur.match && (fifo_data == msg_code_byte(sec_code_i, cur.idx, cur.erased));
					next_cur.idx = cur.idx + 1'b1;
					if (cur.idx == 3'(MSG_SEC_BYTES - 1))
					begin
						next_cur.bypass = next_cur.match;
						next_cur.ram_wr = next_cur.match;
						next_cur.st = MSG_SEND_BREAK;
					end
				end
			end
			MSG_SEND_BREAK:
			begin
				if (!cur.tx_valid)
				begin
					next_cur.tx_valid = 1'b1;
					next_cur.tx_break = 1'b1;
					next_cur.tx_data = '0;
					next_cur.st = MSG_CMD;
				end
			end
			MSG_CMD:
			begin
				if (fifo_valid && fifo_data == MSG_RUN_OPCODE)
				begin
					next_cur.op_valid = 1'b1;
					next_cur.op = MSG_OP_PULL_INDEX_HIGH;
					next_cur.st = MSG_RUN_PUL;
				end
				else if (fifo_valid && fifo_data == MSG_SP_READ_OPCODE)
				begin
					next_cur.sp_lo = sp_plus[7:0];
					next_cur.st = MSG_SP_HI;
				end
			end
			MSG_RUN_PUL:
			begin
				if (cpu_op_done_i)
				begin
					next_cur.op_valid = 1'b1;
					next_cur.op = MSG_OP_INTERRUPT_RETURN;
					next_cur.st = MSG_RUN_RETURN;
				end
			end
			MSG_RUN_RETURN:
			begin
				if (cpu_op_done_i)
				begin
					next_cur.monitor = 1'b0;
					next_cur.st = MSG_IDLE;
				end
			end
			MSG_SP_HI:
			begin
				if (!cur.tx_valid)
				begin
					next_cur.tx_valid = 1'b1;
					next_cur.tx_data = sp_plus[15:8];
					next_cur.st = MSG_SP_LO;
				end
			end
			MSG_SP_LO:
			begin
				if (!cur.tx_valid)
				begin
					next_cur.tx_valid = 1'b1;
					next_cur.tx_data = cur.sp_lo;
					next_cur.st = MSG_CMD;
				end
			end
			default:
				next_cur.st = MSG_IDLE;
		endcase
	end

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			cur <= '0;
			cur.bypass <= cur.bypass && !power_on_i;
			cur.erased <= cur.erased && !power_on_i;
			cur.st <= MSG_IDLE;
		end
		else
			cur <= next_cur;
	end

	// ******************************************
	// Outputs.
	// ******************************************
	assign tx_valid_o = cur.tx_valid;
	assign tx_data_o = cur.tx_data;
	assign tx_break_o = cur.tx_break;
	assign cpu_op_valid_o = cur.op_valid;
	assign cpu_op_o = cur.op;
	assign flash_valid_o = cur.fl_valid;
	assign flash_data_o = cur.fl_data;
	assign illegal_reset_o = cur.illegal;
	assign secure_bypass_o = cur.bypass;
	assign ram_wr_o = cur.ram_wr;
	assign ram_addr_o = MSG_STATUS_ADDR;
	assign ram_wdata_o = 8'(1 << MSG_STATUS_BIT);
endmodule

`default_nettype wire

/* hw/msg_pkg.sv */
/*
 Holds the constants and types of the monitor security gate.
 Assumes one 40 MHz clock and byte-wide serial traffic framed elsewhere.
*/
package msg_pkg;
	localparam int unsigned MSG_SEC_BYTES = 8;
	localparam logic [15:0] MSG_SEC_FIRST_ADDR = 16'hFFF6;
	localparam logic [15:0] MSG_SEC_LAST_ADDR = 16'hFFFD;
	localparam logic [7:0] MSG_BLANK_BYTE = 8'hFF;
	localparam logic [7:0] MSG_RUN_OPCODE = 8'h28;
	localparam logic [7:0] MSG_SP_READ_OPCODE = 8'h0C;
	localparam logic [7:0] MSG_INVALID_DATA = 8'hAD;
	localparam logic [15:0] MSG_SP_OFFSET = 16'h0001;
	localparam logic [15:0] MSG_PC_HI_OFFSET = 16'h0005;
	localparam logic [15:0] MSG_PC_LO_OFFSET = 16'h0006;
	localparam logic [7:0] MSG_STATUS_ADDR = 8'h80;
	localparam int unsigned MSG_STATUS_BIT = 6;
	localparam int unsigned MSG_FIFO_DEPTH = 8;
	localparam int unsigned MSG_FIFO_WIDTH = 8;

	typedef enum logic [1:0]
	{
		MSG_OP_SOFT_INTERRUPT,
		MSG_OP_PUSH_INDEX_HIGH,
		MSG_OP_PULL_INDEX_HIGH,
		MSG_OP_INTERRUPT_RETURN
	} msg_op_t;

	typedef enum logic [3:0]
	{
		MSG_IDLE,
		MSG_STACK_SOFT_INT,
		MSG_STACK_PSH,
		MSG_SEC_WAIT,
		MSG_SEND_BREAK,
		MSG_CMD,
		MSG_RUN_PUL,
		MSG_RUN_RETURN,
		MSG_SP_HI,
		MSG_SP_LO
	} msg_state_t;
endpackage

/* tb/msg_gate_monitor.sv */
/*
 Checker on the msg_gate ports.
 Assumes one clock with synchronous reset srst_i.
*/
`timescale 1ns/1ps
`default_nettype none
module msg_gate_monitor
(
	// Clock, reset and inputs.
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic monitor_entry_i,
	input wire logic cpu_op_done_i,
	input wire logic flash_rd_i,
	input wire logic [7:0] flash_rd_data_i,
	input wire logic flash_fetch_i,
	// Outputs watched.
	input wire logic cpu_op_valid_o,
	input wire msg_pkg::msg_op_t cpu_op_o,
	input wire logic flash_valid_o,
	input wire logic [7:0] flash_data_o,
	input wire logic illegal_reset_o,
	input wire logic secure_bypass_o,
	input wire logic ram_wr_o,
	input wire logic [7:0] ram_addr_o,
	input wire logic [7:0] ram_wdata_o,
	input wire logic tx_valid_o,
	input wire logic [7:0] tx_data_o,
	input wire logic tx_break_o
);
	import msg_pkg::*;
	// ****
	// Checks the op order, the flash guard and the status write.
	// ****
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (srst_i);
	sequence s_op(msg_op_t k);
		cpu_op_valid_o && cpu_op_o == k;
	endsequence
	entry_swi_a: assert property (monitor_entry_i |=> s_op(MSG_OP_SOFT_INTERRUPT)) else $error("entry op");
	push_next_a: assert property (s_op(MSG_OP_SOFT_INTERRUPT) ##0 cpu_op_done_i |=> s_op(MSG_OP_PUSH_INDEX_HIGH))
		else $error("push op");
	return_next_a: assert property (s_op(MSG_OP_PULL_INDEX_HIGH) ##0 cpu_op_done_i |=> s_op(MSG_OP_INTERRUPT_RETURN))
		else $error("return op");
	op_hold_a: assert property (cpu_op_valid_o && !cpu_op_done_i |=> cpu_op_valid_o && $stable(cpu_op_o))
		else $error("op hold");
	flash_open_a: assert property (flash_rd_i && secure_bypass_o |=> flash_valid_o && flash_data_o == $past(flash_rd_data_i))
		else $error("flash open");
	flash_lock_a: assert property (flash_rd_i && !secure_bypass_o |=> flash_data_o == MSG_INVALID_DATA)
		else $error("flash lock");
	fetch_lock_a: assert property (flash_fetch_i && !secure_bypass_o |=> illegal_reset_o) else $error("fetch");
	status_wr_a: assert property (ram_wr_o |-> secure_bypass_o && ram_addr_o == MSG_STATUS_ADDR && ram_wdata_o == 8'h40)
		else $error("status");
	break_after_a: assert property (ram_wr_o |=> tx_valid_o && tx_break_o && tx_data_o == 8'h00) else $error("break");
endmodule
bind msg_gate msg_gate_monitor u_msg_gate_monitor (.*);
`default_nettype wire

/* tb/msg_host_model.sv */
/*
 Host model on the monitor_serial_pin byte stream.
 Assumes the device side may see tx stalls at random.
*/
`timescale 1ns/1ps
`default_nettype none
module msg_host_model
(
	// Clock.
	input wire logic clock_i,
	// Bytes to the device.
	input wire logic rx_ready_i,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	// Bytes from the device.
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_break_i,
	output logic tx_ready_o
);
	logic [8:0] got[$];
	initial
	begin
		rx_valid_o = 1'b0;
		rx_data_o = 8'h00;
		tx_ready_o = 1'b0;
	end
	// ****
	// Sends bytes in order, each held until taken.
	// ****
	task automatic send(input logic [7:0] q[$]);
		@(posedge clock_i);
		foreach (q[i])
		begin
			rx_valid_o <= 1'b1;
			rx_data_o <= q[i];
			do @(posedge clock_i); while (rx_ready_i !== 1'b1);
		end
		rx_valid_o <= 1'b0;
		rx_data_o <= ~q[$];
	endtask
	always @(posedge clock_i)
	begin
		if (tx_valid_i === 1'b1 && tx_ready_o)
			got.push_back({tx_break_i, tx_data_i});
		tx_ready_o <= 1'($urandom_range(1, 0));
	end
endmodule
`default_nettype wire

/* tb/tb_msg_gate.sv */
/*
 Testbench for msg_gate with a host model and a CPU responder.
 Assumes the package constants and a 40 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_msg_gate;
	import msg_pkg::*;
	logic clock_i = 0, srst_i = 1, monitor_entry_i = 0, power_on_i = 1, mass_erase_done_i = 0, cpu_op_done_i = 0;
	logic rx_valid_i, rx_ready_o, tx_valid_o, tx_break_o, tx_ready_i, cpu_op_valid_o, flash_valid_o;
	logic flash_rd_i = 0, flash_fetch_i = 0, illegal_reset_o, secure_bypass_o, ram_wr_o;
	logic [7:0] rx_data_i, tx_data_o, flash_rd_data_i = 0, flash_data_o, ram_addr_o, ram_wdata_o;
	logic [15:0] stack_pointer_i = 0, e;
	logic [63:0] sec_code_i = 0;
	msg_op_t cpu_op_o;
	msg_op_t ops[$];
	logic [7:0] q[$];
	int fail_count = 0, cmp_count = 0, cyc = 0, ram_n = 0, wn = 0;
	always #12.5 clock_i = ~clock_i;
	msg_gate u_msg_gate (.*);
	msg_host_model u_msg_host_model (.clock_i(clock_i), .rx_ready_i(rx_ready_o), .rx_valid_o(rx_valid_i),
		.rx_data_o(rx_data_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_break_i(tx_break_o),
		.tx_ready_o(tx_ready_i));
	// ****
	// CPU responder, status counter and timeout.
	// ****
	always @(posedge clock_i)
	begin
		cyc <= cyc + 1;
		cpu_op_done_i <= 1'b0;
		if (ram_wr_o === 1'b1)
			ram_n <= ram_n + 1;
		if (cpu_op_valid_o !== 1'b1 || cpu_op_done_i)
			wn <= 0;
		else if (wn == 2)
		begin
			cpu_op_done_i <= 1'b1;
			ops.push_back(cpu_op_o);
		end
		else
			wn <= wn + 1;
		if (cyc == 20000)
		begin
			fail_count++;
			stop_test();
		end
	end
	task automatic chk(input string w, input logic [15:0] g, input logic [15:0] x);
		cmp_count++;
		if (g !== x)
		begin
			fail_count++;
			$display("mismatch %s exp %h got %h", w, x, g);
		end
	endtask
	task automatic see_ops(input msg_op_t a, input msg_op_t b);
		for (int i = 0; i < 99 && ops.size() < 2; i++)
			@(posedge clock_i);
		chk("op0", ops[0], a);
		chk("op1", ops[1], b);
		ops = {};
	endtask
	task automatic see_tx(input logic [8:0] a[$]);
		for (int i = 0; i < 199 && u_msg_host_model.got.size() < a.size(); i++)
			@(posedge clock_i);
		foreach (a[i])
			chk("tx", u_msg_host_model.got[i], a[i]);
		u_msg_host_model.got = {};
	endtask
	task automatic rst(input logic por);
		@(posedge clock_i);
		srst_i <= 1'b1;
		power_on_i <= por;
		@(posedge clock_i);
		srst_i <= 1'b0;
	endtask
	task automatic enter(input logic por);
		@(posedge clock_i);
		power_on_i <= por;
		monitor_entry_i <= 1'b1;
		@(posedge clock_i);
		monitor_entry_i <= 1'b0;
		see_ops(MSG_OP_SOFT_INTERRUPT, MSG_OP_PUSH_INDEX_HIGH);
	endtask
	task automatic secure(input int bad, input logic erased);
		int n;
		logic [7:0] b;
		n = ram_n;
		q = {};
		for (int i = 0; i < 8; i++)
		begin
			b = 8'($urandom_range(254, 0));
			sec_code_i[8*i +: 8] <= b;
			q.push_back(erased ? 8'hFF : b ^ {7'h00, i == bad});
		end
		chk("early", u_msg_host_model.got.size(), 0);
		u_msg_host_model.send(q);
		see_tx('{9'h100});
		chk("bypass", secure_bypass_o, bad < 0);
		chk("status", ram_n - n, bad < 0);
	endtask
	task automatic flash(input logic lock);
		logic [7:0] d;
		d = 8'($urandom);
		if (d == MSG_INVALID_DATA)
			d = 8'h00;
		@(posedge clock_i);
		flash_rd_i <= 1'b1;
		flash_fetch_i <= 1'b1;
		flash_rd_data_i <= d;
		@(posedge clock_i);
		flash_rd_i <= 1'b0;
		flash_fetch_i <= 1'b0;
		#1;
		chk("fdata", flash_data_o, lock ? MSG_INVALID_DATA : d);
		chk("illegal", illegal_reset_o, lock);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		void'($urandom(61616));
		repeat (16) @(posedge clock_i);
		srst_i <= 1'b0;
		enter(1'b1);
		secure(-1, 1'b0);
		flash(1'b0);
		$display("test entry done");
		e = 16'($urandom);
		stack_pointer_i <= e;
		e = e + 16'h0001;
		u_msg_host_model.send('{MSG_SP_READ_OPCODE});
		see_tx('{{1'b0, e[15:8]}, {1'b0, e[7:0]}});
		u_msg_host_model.send('{MSG_RUN_OPCODE});
		see_ops(MSG_OP_PULL_INDEX_HIGH, MSG_OP_INTERRUPT_RETURN);
		$display("test commands done");
		rst(1'b0);
		u_msg_host_model.send('{8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55});
		#1;
		chk("full", rx_ready_o, 1'b0);
		enter(1'b0);
		see_tx('{9'h100});
		repeat (12) @(posedge clock_i);
		chk("drain", rx_ready_o, 1'b1);
		chk("kept", secure_bypass_o, 1'b1);
		flash(1'b0);
		$display("test warm reset done");
		rst(1'b1);
		enter(1'b1);
		secure(int'($urandom_range(7, 0)), 1'b0);
		flash(1'b1);
		rst(1'b1);
		@(posedge clock_i);
		mass_erase_done_i <= 1'b1;
		@(posedge clock_i);
		mass_erase_done_i <= 1'b0;
		enter(1'b1);
		secure(-1, 1'b1);
		$display("test failure and erase done");
		stop_test();
	end
endmodule
`default_nettype wire
